// >>> mrdm_pkg.sv
// package for the maintenance register display and modify block
// What this block does
// - fast store pointer selected: no bus load, clear hold, copy pointer directly
// - direct-transfer selection clears stale hold bits before display
// - final hold load strobe only after 170 ms debounce following key press
// - main store pointer goes to buffer, then bus separator feeds hold register
// - pointer bits 00,01,17,18 come from separate flip-flops, buffer bits blocked
// - N selection gates counter flags, aux status, code mode, privilege, key field
// - N selection also gates N counter and general register pointer bits
// - opcode and level views gate only their own field bits
// - utility word: pass Y operand, block hold load, display utility word directly
// - partial selections mask unused input bus bits
// - data key sets its hold bit; clearing only by whole byte
// - load-selected key writes hold register into selected register
// - after write-back the selected register is redisplayed
// - write-back only for modifiable registers and fields
// - write-back under opcode view also overwrites utility word
// - selecting utility word clears hold register; lamps show utility word
// - load key sets first set-cycle ff; it drives hold onto bus while held
// - read-in commands enabled from second set-cycle ff during write-back
// - load key release resets first ff and starts the display cycle
// - processor stopped, utility word not selected: adder passes X operand, lamps show hold register
// - debounce one-shot gives a single 1 us load enable pulse
// - intermediate word selection reads it onto the input bus for loading
package mrdm_pkg;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned DEBOUNCE_MS = 170;
   localparam int unsigned PULSE_US = 1;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
   localparam int unsigned PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int unsigned CNT_W = 25;
   // bit positions taken from separate address flip-flops
   localparam int unsigned BIT_A0 = 0;
   localparam int unsigned BIT_A1 = 1;
   localparam int unsigned BIT_A17 = 17;
   localparam int unsigned BIT_A18 = 18;
   // field masks of partial selections
   localparam logic [31:0] MASK_FSP = 32'h0000007f;
   localparam logic [31:0] MASK_MSP = 32'h0007ffff;
   localparam logic [31:0] MASK_NSEL = 32'h7ff9760f;
   localparam logic [31:0] MASK_OPV = 32'hffeeffff;
   localparam logic [31:0] MASK_LVL = 32'hfffffeff;
   localparam logic [31:0] MASK_FULL = 32'hffffffff;
   // writable fields per selection
   localparam logic [31:0] WR_NSEL = 32'h7ff90000;
   localparam logic [31:0] WR_OPV = 32'h3f00ffff;
   // selection codes, one-hot from the select key gang
   localparam int unsigned SEL_W = 8;
   localparam logic [7:0] SEL_FSP = 8'h01;
   localparam logic [7:0] SEL_MSP = 8'h02;
   localparam logic [7:0] SEL_MSB = 8'h04;
   localparam logic [7:0] SEL_UTL = 8'h08;
   localparam logic [7:0] SEL_INT = 8'h10;
   localparam logic [7:0] SEL_OPV = 8'h20;
   localparam logic [7:0] SEL_NSL = 8'h40;
   localparam logic [7:0] SEL_LVL = 8'h80;

   typedef enum logic [4:0] {
      MRDM_IDLE = 5'h01,
      MRDM_WAIT = 5'h02,
      MRDM_LOAD = 5'h04,
      MRDM_SET1 = 5'h08,
      MRDM_SET2 = 5'h10
   } mrdm_state_t;

   typedef struct packed {
      logic [31:0] fsp;
      logic [31:0] msp;
      logic [31:0] msb;
      logic [31:0] utl;
      logic [31:0] intw;
      logic [31:0] opv;
      logic [31:0] nsel;
      logic [31:0] lvl;
   } mrdm_srcs_t;

   typedef struct packed {
      logic [7:0] sel;
      logic [31:0] data;
      logic [31:0] wmask;
   } mrdm_wb_t;
endpackage

// >>> mrdm_top.sv
// maintenance panel register display and modify logic
`timescale 1ns/1ps
module mrdm_top #(
   parameter int unsigned DEBOUNCE_CYC = mrdm_pkg::DEBOUNCE_CYC,
   parameter int unsigned PULSE_CYC = mrdm_pkg::PULSE_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // panel keys
   input wire logic [7:0] select_keys,
   input wire logic [31:0] data_keys,
   input wire logic [3:0] byte_clear_keys,
   input wire logic load_selected_key,
   // processor side
   input wire logic proc_running,
   input wire mrdm_pkg::mrdm_srcs_t srcs,
   input wire logic [3:0] low_byte_addr_ffs,
   // outputs
   output logic [31:0] lamps,
   output mrdm_pkg::mrdm_wb_t wb,
   output logic wb_strobe
);
   // one shared counter: longer timings would wrap before reaching their limit
   if (DEBOUNCE_CYC < 1 || DEBOUNCE_CYC >= (1 << mrdm_pkg::CNT_W) || PULSE_CYC < 1
         || PULSE_CYC >= (1 << mrdm_pkg::CNT_W)) begin
      $error("mrdm_top: bad timing parameters");
   end

   localparam logic [7:0] A_HOLD = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_CTRL = 8'h08;

   typedef struct packed {
      mrdm_pkg::mrdm_state_t st;
      logic [24:0] cnt;
      logic [7:0] sel;
      logic [7:0] keys_q;
      logic load_q;
      logic display_cycle_arm_ff;
      logic set_cycle_first_ff;
      logic set_cycle_second_ff;
      logic [31:0] data_hold_reg;
      logic [31:0] wb_data;
      logic [31:0] wb_mask;
      logic [7:0] wb_sel;
      logic wb_stb;
      logic [31:0] lamps;
      logic aw_got;
      logic w_got;
      logic [31:0] w_buf;
      logic [7:0] aw_buf;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic sw_load;
      logic sw_key_en;
   } mrdm_st_t;

   mrdm_st_t s_ff;
   mrdm_st_t nxt_s;

   function automatic logic [31:0] mrdm_mask(input logic [7:0] sel);
      unique case (sel)
         mrdm_pkg::SEL_FSP: mrdm_mask = mrdm_pkg::MASK_FSP;
         mrdm_pkg::SEL_MSP: mrdm_mask = mrdm_pkg::MASK_MSP;
         mrdm_pkg::SEL_NSL: mrdm_mask = mrdm_pkg::MASK_NSEL;
         mrdm_pkg::SEL_OPV: mrdm_mask = mrdm_pkg::MASK_OPV;
         mrdm_pkg::SEL_LVL: mrdm_mask = mrdm_pkg::MASK_LVL;
         default: mrdm_mask = mrdm_pkg::MASK_FULL;
      endcase
   endfunction

   function automatic logic [31:0] mrdm_wmask(input logic [7:0] sel);
      unique case (sel)
         mrdm_pkg::SEL_NSL: mrdm_wmask = mrdm_pkg::WR_NSEL;
         mrdm_pkg::SEL_OPV: mrdm_wmask = mrdm_pkg::WR_OPV;
         mrdm_pkg::SEL_MSB, mrdm_pkg::SEL_UTL, mrdm_pkg::SEL_INT: mrdm_wmask = 32'hffffffff;
         default: mrdm_wmask = 32'h00000000;
      endcase
   endfunction

   logic [31:0] input_bus;
   logic [31:0] msp_view;
   logic [31:0] partial_read_mask;
   logic direct_sel;
   logic one_hot;
   logic pass_x_operand;
   logic pass_y_operand;
   logic hold_load_strobe;
   logic hold_clear_strobe;
   logic [7:0] eff_keys;
   logic eff_load;

   always_comb begin
      eff_keys = select_keys | s_ff.keys_q;
      eff_load = load_selected_key | s_ff.sw_load;
      one_hot = (eff_keys != 8'h00) && ((eff_keys & (eff_keys - 8'h01)) == 8'h00);
      msp_view = srcs.msp;
      // address bits kept outside the store replace the buffer bits
      msp_view[mrdm_pkg::BIT_A0] = low_byte_addr_ffs[0];
      msp_view[mrdm_pkg::BIT_A1] = low_byte_addr_ffs[1];
      msp_view[mrdm_pkg::BIT_A17] = low_byte_addr_ffs[2];
      msp_view[mrdm_pkg::BIT_A18] = low_byte_addr_ffs[3];
      partial_read_mask = mrdm_mask(s_ff.sel);
      unique case (s_ff.sel)
         mrdm_pkg::SEL_MSP: input_bus = msp_view;
         mrdm_pkg::SEL_MSB: input_bus = srcs.msb;
         mrdm_pkg::SEL_INT: input_bus = srcs.intw;
         mrdm_pkg::SEL_NSL: input_bus = srcs.nsel;
         mrdm_pkg::SEL_OPV: input_bus = srcs.opv;
         mrdm_pkg::SEL_LVL: input_bus = srcs.lvl;
         default: input_bus = 32'h00000000;
      endcase
      input_bus = input_bus & partial_read_mask;
      if (s_ff.set_cycle_first_ff) begin
         input_bus = s_ff.data_hold_reg;
      end
      direct_sel = (s_ff.sel == mrdm_pkg::SEL_FSP) || (s_ff.sel == mrdm_pkg::SEL_UTL);
      pass_y_operand = (s_ff.sel == mrdm_pkg::SEL_UTL) && !proc_running;
      pass_x_operand = !proc_running && !pass_y_operand;
      hold_load_strobe = (s_ff.st == mrdm_pkg::MRDM_LOAD) && !direct_sel;
      hold_clear_strobe = (s_ff.st == mrdm_pkg::MRDM_LOAD) && direct_sel;
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.keys_q = 8'h00;
      nxt_s.sw_load = s_ff.sw_load && load_selected_key;
      nxt_s.wb_stb = 1'b0;
      nxt_s.load_q = eff_load;
      // ---------------------------------------------
      // key cycle
      // ---------------------------------------------
      if (!proc_running) begin
         if (one_hot && eff_keys != s_ff.sel) begin
            nxt_s.sel = eff_keys;
            nxt_s.display_cycle_arm_ff = 1'b1;
            nxt_s.st = mrdm_pkg::MRDM_WAIT;
            nxt_s.cnt = '0;
            nxt_s.set_cycle_first_ff = 1'b0;
            nxt_s.set_cycle_second_ff = 1'b0;
         end else begin
            unique case (s_ff.st)
               mrdm_pkg::MRDM_IDLE: begin
                  if (eff_load && !s_ff.load_q && s_ff.sel != 8'h00) begin
                     nxt_s.set_cycle_first_ff = 1'b1;
                     nxt_s.set_cycle_second_ff = 1'b1;
                     nxt_s.st = mrdm_pkg::MRDM_SET1;
                  end
               end
               mrdm_pkg::MRDM_WAIT: begin
                  nxt_s.cnt = s_ff.cnt + 25'd1;
                  if (s_ff.cnt == 25'(DEBOUNCE_CYC - 1)) begin
                     nxt_s.cnt = '0;
                     nxt_s.st = mrdm_pkg::MRDM_LOAD;
                  end
               end
               mrdm_pkg::MRDM_LOAD: begin
                  nxt_s.cnt = s_ff.cnt + 25'd1;
                  if (s_ff.cnt == 25'd0) begin
                     if (hold_clear_strobe) begin
                        nxt_s.data_hold_reg = '0;
                        if (s_ff.sel == mrdm_pkg::SEL_FSP) begin
                           nxt_s.data_hold_reg = srcs.fsp & mrdm_pkg::MASK_FSP;
                        end
                     end else if (hold_load_strobe) begin
                        nxt_s.data_hold_reg = input_bus;
                     end
                  end
                  if (s_ff.cnt == 25'(PULSE_CYC - 1)) begin
                     nxt_s.cnt = '0;
                     nxt_s.display_cycle_arm_ff = 1'b0;
                     nxt_s.st = mrdm_pkg::MRDM_IDLE;
                  end
               end
               mrdm_pkg::MRDM_SET1: begin
                  if (s_ff.set_cycle_second_ff) begin
                     nxt_s.wb_sel = s_ff.sel;
                     nxt_s.wb_data = input_bus;
                     nxt_s.wb_mask = mrdm_wmask(s_ff.sel);
                     nxt_s.wb_stb = (mrdm_wmask(s_ff.sel) != 32'h00000000);
                     nxt_s.set_cycle_second_ff = 1'b0;
                  end
                  if (!eff_load) begin
                     nxt_s.set_cycle_first_ff = 1'b0;
                     nxt_s.st = mrdm_pkg::MRDM_SET2;
                  end
               end
               mrdm_pkg::MRDM_SET2: begin
                  nxt_s.display_cycle_arm_ff = 1'b1;
                  nxt_s.cnt = '0;
                  nxt_s.st = mrdm_pkg::MRDM_WAIT;
               end
               default: nxt_s.st = mrdm_pkg::MRDM_IDLE;
            endcase
         end
         if (s_ff.st == mrdm_pkg::MRDM_IDLE || s_ff.st == mrdm_pkg::MRDM_SET1) begin
            nxt_s.data_hold_reg = nxt_s.data_hold_reg | (data_keys & {32{s_ff.sw_key_en}}) | data_keys;
            for (int b = 0; b < 4; b++) begin
               if (byte_clear_keys[b]) begin
                  nxt_s.data_hold_reg[b*8 +: 8] = data_keys[b*8 +: 8];
               end
            end
         end
      end
      // opcode view write-back also lands in the utility word downstream
      if (nxt_s.wb_stb && s_ff.sel == mrdm_pkg::SEL_OPV) begin
         nxt_s.wb_sel = mrdm_pkg::SEL_OPV | mrdm_pkg::SEL_UTL;
      end
      // ---------------------------------------------
      // lamps
      // ---------------------------------------------
      if (pass_y_operand) begin
         nxt_s.lamps = srcs.utl;
      end else if (pass_x_operand) begin
         nxt_s.lamps = s_ff.data_hold_reg;
      end else begin
         nxt_s.lamps = 32'h00000000;
      end
      // ---------------------------------------------
      // bus slave
      // ---------------------------------------------
      if (s_axi_awvalid && !s_ff.aw_got) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.aw_buf = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_ff.w_got) begin
         nxt_s.w_got = 1'b1;
         nxt_s.w_buf = s_axi_wdata;
      end
      if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = 2'b00;
         if (s_ff.aw_buf == A_CTRL) begin
            nxt_s.keys_q = s_ff.w_buf[7:0];
            nxt_s.sw_load = s_ff.w_buf[8];
            nxt_s.sw_key_en = s_ff.w_buf[9];
         end else if (s_ff.aw_buf != A_HOLD && s_ff.aw_buf != A_STAT) begin
            nxt_s.bresp = 2'b10;
         end
      end
      if (s_ff.bvalid && s_axi_bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_ff.rvalid) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp = 2'b00;
         unique case (s_axi_araddr)
            A_HOLD: nxt_s.rdata = s_ff.data_hold_reg;
            A_STAT: nxt_s.rdata = {16'h0000, s_ff.sel, 3'b000, s_ff.st};
            A_CTRL: nxt_s.rdata = {22'h000000, s_ff.sw_key_en, s_ff.sw_load, 8'h00};
            default: begin
               nxt_s.rdata = 32'h00000000;
               nxt_s.rresp = 2'b10;
            end
         endcase
      end
      if (s_ff.rvalid && s_axi_rready) begin
         nxt_s.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= '0;
         s_ff.st <= mrdm_pkg::MRDM_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign s_axi_awready = !s_ff.aw_got;
   assign s_axi_wready = !s_ff.w_got;
   assign s_axi_bvalid = s_ff.bvalid;
   assign s_axi_bresp = s_ff.bresp;
   assign s_axi_arready = !s_ff.rvalid;
   assign s_axi_rvalid = s_ff.rvalid;
   assign s_axi_rdata = s_ff.rdata;
   assign s_axi_rresp = s_ff.rresp;
   assign lamps = s_ff.lamps;
   assign wb.sel = s_ff.wb_sel;
   assign wb.data = s_ff.wb_data;
   assign wb.wmask = s_ff.wb_mask;
   assign wb_strobe = s_ff.wb_stb;
endmodule

// >>> mrdm_top_properties.sv
// checker on the display and modify block ports
`timescale 1ns/1ps
module mrdm_top_properties #(
   parameter int unsigned DEBOUNCE_CYC = mrdm_pkg::DEBOUNCE_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // keys and processor
   input wire logic [7:0] select_keys,
   input wire logic load_selected_key,
   input wire logic proc_running,
   // outputs
   input wire logic [31:0] lamps,
   input wire mrdm_pkg::mrdm_wb_t wb,
   input wire logic wb_strobe
);
   // ----------
   // cycles since the selection moved
   // ----------
   logic [31:0] since_ff;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         since_ff <= 32'hffffffff;
      end else if (select_keys != $past(select_keys)) begin
         since_ff <= 32'h0;
      end else if (since_ff != 32'hffffffff) begin
         since_ff <= since_ff + 32'h1;
      end
   end
   // ----------
   // properties
   // ----------
   // two cycles skipped: lamps may still finish the old view
   debounce_hold_a: assert property (
      since_ff >= 32'h2 && {1'b0, since_ff} + 33'h2 <= DEBOUNCE_CYC |-> $stable(lamps))
      else $error("hold loaded before debounce ran out");
   wb_pulse_a: assert property (wb_strobe |=> !wb_strobe)
      else $error("write-back strobe longer than one cycle");
   run_dark_a: assert property (proc_running |=> lamps == 32'h0)
      else $error("lamps lit while running");
   run_nowb_a: assert property (proc_running ##1 proc_running |-> !wb_strobe)
      else $error("write-back while running");
   // fsp, msp and level views are display only
   wb_legal_a: assert property (wb_strobe |-> (wb.sel & 8'h83) == 8'h00)
      else $error("write-back to a display-only selection");
   opv_side_a: assert property (wb_strobe && wb.sel[5] |-> wb.sel[3])
      else $error("opcode write-back spared the utility word");
   wb_start_a: assert property (
      $rose(load_selected_key) && !proc_running && (select_keys & 8'h7c) != 8'h00
      && $onehot(select_keys) |-> ##[1:3] wb_strobe) else $error("set key gave no write-back");
   wb_cause_a: assert property (
      wb_strobe |-> $past(load_selected_key, 2))
      else $error("write-back without set key");
endmodule
bind mrdm_top mrdm_top_properties #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_props (
   .aclk(aclk), .aresetn(aresetn), .select_keys(select_keys),
   .load_selected_key(load_selected_key), .proc_running(proc_running),
   .lamps(lamps), .wb(wb), .wb_strobe(wb_strobe)
);

// >>> mrdm_panel.sv
// operator panel model driving the keys of the block
`timescale 1ns/1ps
module mrdm_panel (
   // clock
   input wire logic aclk,
   // keys
   output logic [7:0] select_keys,
   output logic [31:0] data_keys,
   output logic [3:0] byte_clear_keys,
   output logic load_selected_key
);
   // a key let go reads low at once; keys move only just after an edge
   initial begin
      select_keys = 8'h00;
      data_keys = 32'h0;
      byte_clear_keys = 4'h0;
      load_selected_key = 1'b0;
   end
   // the gang keeps one key down until another is pressed
   task automatic sel(input logic [7:0] k);
      @(posedge aclk);
      select_keys <= k;
   endtask
   // data and byte clear keys are momentary
   task automatic keys(input logic [31:0] d, input logic [3:0] c);
      @(posedge aclk);
      data_keys <= d;
      byte_clear_keys <= c;
      repeat (2) @(posedge aclk);
      data_keys <= 32'h0;
      byte_clear_keys <= 4'h0;
   endtask
   // hold time chosen by caller: quick or slow operator
   task automatic set_reg(input int n);
      @(posedge aclk);
      load_selected_key <= 1'b1;
      repeat (n) @(posedge aclk);
      load_selected_key <= 1'b0;
   endtask
endmodule

// >>> mrdm_top_tb.sv
// self-checking bench of the display and modify block
`timescale 1ns/1ps
module mrdm_top_tb;
   localparam int D = 20;
   localparam int P = 3;
   localparam int SETTLE = D + P + 12;
   logic aclk, aresetn, proc_running, load_selected_key, wb_strobe;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, select_keys, last_sel;
   logic [31:0] s_axi_wdata, s_axi_rdata, data_keys, lamps, rd, last_mask, last_data;
   logic [3:0] s_axi_wstrb, byte_clear_keys, low_byte_addr_ffs;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   mrdm_pkg::mrdm_srcs_t srcs;
   mrdm_pkg::mrdm_wb_t wb;
   int failures, checked, strobes, cyc;
   mrdm_top #(.DEBOUNCE_CYC(D), .PULSE_CYC(P)) DUT (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .select_keys, .data_keys, .byte_clear_keys, .load_selected_key,
      .proc_running, .srcs, .low_byte_addr_ffs, .lamps, .wb, .wb_strobe
   );
   mrdm_panel panel (.aclk, .select_keys, .data_keys, .byte_clear_keys, .load_selected_key);
   always #4 aclk = ~aclk;
   // processor takes write-backs; sampled off the edge to avoid races
   always @(negedge aclk) begin
      if (wb_strobe === 1'b1) begin
         strobes++;
         last_sel <= wb.sel;
         last_mask <= wb.wmask;
         last_data <= wb.data;
         if (wb.sel[3]) srcs.utl <= wb.data;
      end
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         wrap_up;
      end
   end
   // ----------
   // bus and compare tasks
   // ----------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ha, done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(negedge aclk);
         ha = s_axi_arvalid && s_axi_arready === 1'b1;
         done = s_axi_rvalid === 1'b1;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ha) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      logic ha, hw, done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(negedge aclk);
         ha = s_axi_awvalid && s_axi_awready === 1'b1;
         hw = s_axi_wvalid && s_axi_wready === 1'b1;
         done = s_axi_bvalid === 1'b1;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic hold_is(input logic [31:0] e);
      axi_rd(8'h00, rd, rs);
      chk("hold", e, rd);
   endtask
   task automatic wrap_up;
      if (failures == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_bus;
      axi_rd(8'h0c, rd, rs);
      chk("rd_resp", 32'h2, {30'h0, rs});
      chk("rd_data", 32'h0, rd);
      axi_wr(8'h0c, 32'h1, rs);
      chk("wr_resp", 32'h2, {30'h0, rs});
      axi_rd(8'h04, rd, rs);
      chk("stat", 32'h1, rd);
   endtask
   task automatic t_fsp;
      int n;
      panel.keys(32'hffff0000, 4'h0);
      hold_is(32'hffff0000);
      chk("idle_lamps", 32'hffff0000, lamps);
      panel.sel(mrdm_pkg::SEL_FSP);
      repeat (SETTLE) @(posedge aclk);
      chk("fsp_lamps", 32'h75, lamps);
      n = strobes;
      panel.set_reg(4);
      repeat (SETTLE) @(posedge aclk);
      chk("fsp_nowb", n, strobes);
   endtask
   task automatic t_views;
      logic [7:0] ks [5];
      logic [31:0] ex [5];
      ks = '{mrdm_pkg::SEL_MSP, mrdm_pkg::SEL_MSB, mrdm_pkg::SEL_INT, mrdm_pkg::SEL_NSL,
             mrdm_pkg::SEL_LVL};
      ex = '{32'h0003fffd, 32'hc3c3c3c3, 32'h12345678, mrdm_pkg::MASK_NSEL, mrdm_pkg::MASK_LVL};
      // abandoned selection must restart the cycle
      panel.sel(mrdm_pkg::SEL_LVL);
      repeat (5) @(posedge aclk);
      for (int i = 0; i < 5; i++) begin
         panel.sel(ks[i]);
         repeat (SETTLE) @(posedge aclk);
         chk("view", ex[i], lamps);
      end
   endtask
   task automatic t_utl;
      panel.sel(mrdm_pkg::SEL_UTL);
      repeat (SETTLE) @(posedge aclk);
      chk("utl_lamps", 32'h0badf00d, lamps);
      hold_is(32'h0);
      panel.keys(32'ha5a5a5a5, 4'h0);
      panel.keys(32'h0, 4'h1);
      hold_is(32'ha5a5a500);
      chk("utl_hidden", 32'h0badf00d, lamps);
      panel.set_reg(4);
      repeat (SETTLE) @(posedge aclk);
      chk("utl_wb", 32'ha5a5a500, srcs.utl);
      chk("utl_redisp", 32'ha5a5a500, lamps);
   endtask
   task automatic t_opv;
      panel.sel(mrdm_pkg::SEL_OPV);
      repeat (SETTLE) @(posedge aclk);
      chk("opv_lamps", 32'h89aacdef, lamps);
      panel.set_reg(2);
      repeat (SETTLE) @(posedge aclk);
      chk("opv_sel", {24'h0, mrdm_pkg::SEL_OPV | mrdm_pkg::SEL_UTL}, {24'h0, last_sel});
      chk("opv_mask", mrdm_pkg::WR_OPV, last_mask);
      chk("opv_data", 32'h89aacdef, last_data);
   endtask
   task automatic t_run;
      int n;
      n = strobes;
      @(posedge aclk);
      proc_running <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("run_dark", 32'h0, lamps);
      panel.sel(mrdm_pkg::SEL_NSL);
      panel.set_reg(4);
      repeat (SETTLE) @(posedge aclk);
      chk("run_nowb", n, strobes);
   endtask
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      proc_running = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      low_byte_addr_ffs = 4'h5;
      srcs = '{32'hfffffff5, 32'hffffffff, 32'hc3c3c3c3, 32'h0badf00d, 32'h12345678,
               32'h89abcdef, 32'hffffffff, 32'hffffffff};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_bus;
      t_fsp;
      t_views;
      t_utl;
      t_opv;
      t_run;
      wrap_up;
   end
endmodule
